// ===== logic/dfs_pkg.sv
`default_nettype none
package dfs_pkg;
	localparam int unsigned CLK_HZ      = 50_000_000;
	localparam int unsigned EIGHTH_MS   = 125;
	localparam int unsigned EIGHTH_CYC  = CLK_HZ / 1000 * EIGHTH_MS;
	localparam int unsigned FAN_MS      = 500;
	localparam int unsigned TEMP_MS     = 1000;
	localparam logic [2:0]  FAN_SLOTS   = 3'(FAN_MS / EIGHTH_MS);
	localparam logic [3:0]  TEMP_SLOTS  = 4'(TEMP_MS / EIGHTH_MS);

	localparam logic [7:0] TYP_MEMRD    = 8'h0a;
	localparam logic [7:0] TYP_CURPOS   = 8'h0b;
	localparam logic [7:0] TYP_CURSTY   = 8'h0c;
	localparam logic [7:0] TYP_CONTR    = 8'h0d;
	localparam logic [7:0] TYP_BKLT     = 8'h0e;
	localparam logic [7:0] TYP_FANRPT   = 8'h10;
	localparam logic [7:0] TYP_FANPWR   = 8'h11;
	localparam logic [7:0] TYP_SNSRD    = 8'h12;
	localparam logic [7:0] TYP_TMPRPT   = 8'h13;
	localparam logic [7:0] ACK_BIT      = 8'h40;
	localparam logic [7:0] ERR_BITS     = 8'hc0;
	localparam logic [7:0] TYP_FAN_SPD  = 8'h81;

	localparam logic [4:0] LEN_ONE      = 5'h01;
	localparam logic [4:0] LEN_TWO      = 5'h02;
	localparam logic [4:0] LEN_FOUR     = 5'h04;
	localparam logic [4:0] LEN_READ     = 5'h09;
	localparam logic [3:0] MEM_BYTES    = 4'h8;

	localparam logic [7:0] GLYPH_LO     = 8'h40;
	localparam logic [7:0] CHAR_LO      = 8'h80;
	localparam logic [4:0] ROW_CELLS    = 5'h14;
	localparam logic [4:0] COL_MAX      = 5'h13;
	localparam logic [1:0] ROW_MAX      = 2'h3;
	localparam logic [7:0] CONTR_MAX    = 8'hfe;
	localparam logic [6:0] LEVEL_MAX    = 7'h64;
	localparam logic [7:0] FANMASK_MAX  = 8'h0f;
	localparam logic [7:0] IDX_MAX      = 8'h1f;
	localparam logic [1:0] FAN_DEAD     = 2'h3;

	// arbitrary value, set to the family code of the fitted sensors
	localparam logic [7:0] TEMP_FAMILY  = 8'h5a;

	localparam logic [7:0] RST_CONTR    = 8'h78;
	localparam logic [6:0] RST_BKLT     = 7'h64;
	localparam logic [6:0] RST_FANPWR   = 7'h64;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_READ = 2'b01,
		ST_DONE = 2'b11
	} dfs_state_type;
endpackage
`default_nettype wire

// ===== logic/dfs_tick_timer.sv
`timescale 1ns/100ps
`default_nettype none
module dfs_tick_timer #(
	parameter int unsigned PERIOD = 8
) (
	input  wire logic clock,
	input  wire logic reset_n,
	output logic      tick
);
	logic [31:0] cnt_q;
	logic [31:0] cnt_d;

	always_comb begin
		cnt_d = cnt_q + 32'h1;
		if (cnt_q == 32'(PERIOD - 1)) begin
			cnt_d = 32'h0;
		end
	end

	always_ff @(posedge clock) begin
		if (!reset_n) begin
			cnt_q <= 32'h0;
		end else begin
			cnt_q <= cnt_d;
		end
	end

	assign tick = (cnt_q == 32'(PERIOD - 1));
endmodule // dfs_tick_timer
`default_nettype wire

// ===== logic/dfs_cmd_handler.sv
// Implementation choices: the plain strobed port and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
module dfs_cmd_handler #(
	parameter int unsigned EIGHTH_CYCLES = dfs_pkg::EIGHTH_CYC
) (
	input  wire logic        clock,
	input  wire logic        reset_n,
	input  wire logic        cmd_valid,
	output logic             cmd_ready,
	input  wire logic [7:0]  cmd_type,
	input  wire logic [4:0]  cmd_len,
	input  wire logic [31:0] cmd_data,
	output logic             rsp_valid,
	output logic [7:0]       rsp_type,
	output logic [4:0]       rsp_len,
	output logic [71:0]      rsp_data,
	output logic             mem_rd,
	output logic [7:0]       mem_addr,
	input  wire logic [7:0]  mem_rd_data,
	input  wire logic        enum_wr,
	input  wire logic [4:0]  enum_idx,
	input  wire logic [63:0] enum_id,
	input  wire logic        save_state,
	output logic [4:0]       cursor_col,
	output logic [1:0]       cursor_row,
	output logic [1:0]       cursor_style,
	output logic [7:0]       contrast,
	output logic [6:0]       backlight,
	output logic [27:0]      fan_drive,
	output logic [3:0]       fan_mask,
	output logic [31:0]      temp_mask,
	output logic [52:0]      saved_state,
	output logic             fan_rpt_valid,
	output logic [1:0]       fan_rpt_idx,
	output logic             temp_rpt_valid,
	output logic [31:0]      temp_rpt_mask
);
	dfs_pkg::dfs_state_type state_q, state_d;
	logic [3:0]  cnt_q, cnt_d, fmask_q, fmask_d;
	logic [7:0]  addr_q, addr_d, rt_q, rt_d, con_q, con_d;
	logic [71:0] buf_q, buf_d;
	logic        rv_q, rv_d, frv_q, frv_d, trv_q, trv_d;
	logic [4:0]  rl_q, rl_d, col_q, col_d;
	logic [1:0]  row_q, row_d, sty_q, sty_d, fidx_q, fidx_d;
	logic [6:0]  bkl_q, bkl_d;
	logic [27:0] pwr_q, pwr_d, drv_q, drv_d;
	logic [31:0] tmask_q, tmask_d, family_q, family_d;
	logic [52:0] saved_q, saved_d;
	logic [2:0]  slot_q, slot_d;
	logic [63:0] id_mem [32];
	logic        tick, take, ok;
	logic [7:0]  b0, b1, b2, b3;
	dfs_tick_timer #(
		.PERIOD (EIGHTH_CYCLES)
	) u_eighth (
		.clock   (clock),
		.reset_n (reset_n),
		.tick    (tick)
	);

	assign take = cmd_valid && cmd_ready;
	assign b0 = cmd_data[7:0];
	assign b1 = cmd_data[15:8];
	assign b2 = cmd_data[23:16];
	assign b3 = cmd_data[31:24];

	// sensor table written by the enumeration engine at power-up
	always_ff @(posedge clock) begin
		if (enum_wr) begin
			id_mem[enum_idx] <= enum_id;
		end
	end

	always_comb begin
		family_d = family_q;
		if (enum_wr) begin
			family_d[enum_idx] = (enum_id[7:0] == dfs_pkg::TEMP_FAMILY);
		end
	end

	// command decode and reply build
	always_comb begin
		state_d = state_q;
		cnt_d   = cnt_q;
		addr_d  = addr_q;
		buf_d   = buf_q;
		rv_d    = 1'b0;
		rt_d    = rt_q;
		rl_d    = rl_q;
		col_d   = col_q;
		row_d   = row_q;
		sty_d   = sty_q;
		con_d   = con_q;
		bkl_d   = bkl_q;
		pwr_d   = pwr_q;
		fmask_d = fmask_q;
		tmask_d = tmask_q;
		ok      = 1'b0;
		case (state_q)
			dfs_pkg::ST_IDLE: begin
				if (take) begin
					rl_d = 5'h0;
					case (cmd_type)
						dfs_pkg::TYP_MEMRD: begin
							ok = cmd_len == dfs_pkg::LEN_ONE && b0 >= dfs_pkg::GLYPH_LO
								&& (b0 < dfs_pkg::CHAR_LO || b0[4:0] < dfs_pkg::ROW_CELLS);
							if (ok) begin
								state_d = dfs_pkg::ST_READ;
								addr_d  = b0;
								cnt_d   = 4'h0;
								buf_d   = {64'h0, b0};
							end
						end
						dfs_pkg::TYP_CURPOS: begin
							ok = cmd_len == dfs_pkg::LEN_TWO && b0 <= 8'(dfs_pkg::COL_MAX)
								&& b1 <= 8'(dfs_pkg::ROW_MAX);
							if (ok) begin
								col_d = b0[4:0];
								row_d = b1[1:0];
							end
						end
						dfs_pkg::TYP_CURSTY: begin
							ok = cmd_len == dfs_pkg::LEN_ONE && b0 <= 8'h03;
							if (ok) sty_d = b0[1:0];
						end
						dfs_pkg::TYP_CONTR: begin
							ok = cmd_len == dfs_pkg::LEN_ONE && b0 <= dfs_pkg::CONTR_MAX;
							if (ok) con_d = b0;
						end
						dfs_pkg::TYP_BKLT: begin
							ok = cmd_len == dfs_pkg::LEN_ONE && b0 <= 8'(dfs_pkg::LEVEL_MAX);
							if (ok) bkl_d = b0[6:0];
						end
						dfs_pkg::TYP_FANRPT: begin
							ok = cmd_len == dfs_pkg::LEN_ONE && b0 <= dfs_pkg::FANMASK_MAX;
							if (ok) fmask_d = b0[3:0];
						end
						dfs_pkg::TYP_FANPWR: begin
							ok = cmd_len == dfs_pkg::LEN_FOUR && b0 <= 8'(dfs_pkg::LEVEL_MAX)
								&& b1 <= 8'(dfs_pkg::LEVEL_MAX) && b2 <= 8'(dfs_pkg::LEVEL_MAX)
								&& b3 <= 8'(dfs_pkg::LEVEL_MAX);
							if (ok) begin
								pwr_d = {b3[6:0], b2[6:0], b1[6:0], b0[6:0]};
							end
						end
						dfs_pkg::TYP_SNSRD: begin
							ok = cmd_len == dfs_pkg::LEN_ONE && b0 <= dfs_pkg::IDX_MAX;
							if (ok) begin
								buf_d = {id_mem[b0[4:0]], b0};
								rl_d  = dfs_pkg::LEN_READ;
							end
						end
						dfs_pkg::TYP_TMPRPT: begin
							ok = cmd_len == dfs_pkg::LEN_FOUR;
							if (ok) tmask_d = cmd_data;
						end
						default: ok = 1'b0;
					endcase
					if (!ok) begin
						rt_d = cmd_type | dfs_pkg::ERR_BITS;
						rl_d = 5'h0;
						rv_d = 1'b1;
					end else if (cmd_type != dfs_pkg::TYP_MEMRD) begin
						rt_d = cmd_type | dfs_pkg::ACK_BIT;
						rv_d = 1'b1;
					end
				end
			end
			dfs_pkg::ST_READ: begin
				// data for the request issued at cnt arrives one cycle later
				cnt_d = cnt_q + 4'h1;
				if (cnt_q != 4'h0) begin
					buf_d[8 * cnt_q +: 8] = mem_rd_data;
				end
				if (cnt_q == dfs_pkg::MEM_BYTES) begin
					state_d = dfs_pkg::ST_DONE;
				end
			end
			dfs_pkg::ST_DONE: begin
				rt_d    = dfs_pkg::TYP_MEMRD | dfs_pkg::ACK_BIT;
				rl_d    = dfs_pkg::LEN_READ;
				rv_d    = 1'b1;
				state_d = dfs_pkg::ST_IDLE;
			end
			default: state_d = dfs_pkg::ST_IDLE;
		endcase
	end

	assign mem_rd    = (state_q == dfs_pkg::ST_READ) && (cnt_q < dfs_pkg::MEM_BYTES);
	assign mem_addr  = addr_q + {4'h0, cnt_q};
	assign cmd_ready = (state_q == dfs_pkg::ST_IDLE);

	// snapshot of the settings that survive a power cycle
	always_comb begin
		saved_d = saved_q;
		if (save_state) begin
			saved_d = {1'b0, pwr_q, bkl_q, con_q, sty_q, row_q, col_q};
		end
	end

	// eighth-second slots: fans 1-3 in slots 0-2 of each half second
	always_comb begin
		slot_d = slot_q;
		frv_d  = 1'b0;
		fidx_d = fidx_q;
		trv_d  = 1'b0;
		if (tick) begin
			slot_d = slot_q + 3'h1;
			fidx_d = slot_d[1:0];
			// fan 4 has no tachometer, its slot stays silent
			frv_d  = fmask_q[slot_d[1:0]] && slot_d[1:0] != dfs_pkg::FAN_DEAD;
			trv_d  = slot_d == 3'h0 && |(tmask_q & family_q);
		end
		for (int k = 0; k < 4; k++) begin
			drv_d[7 * k +: 7] = (fmask_q[k] && slot_q[1:0] == 2'(k))
				? dfs_pkg::LEVEL_MAX : pwr_q[7 * k +: 7];
		end
	end

	always_ff @(posedge clock) begin
		if (!reset_n) begin
			state_q  <= dfs_pkg::ST_IDLE;
			cnt_q    <= 4'h0;
			addr_q   <= 8'h0;
			buf_q    <= 72'h0;
			rv_q     <= 1'b0;
			rt_q     <= 8'h0;
			rl_q     <= 5'h0;
			col_q    <= 5'h0;
			row_q    <= 2'h0;
			sty_q    <= 2'h0;
			con_q    <= dfs_pkg::RST_CONTR;
			bkl_q    <= dfs_pkg::RST_BKLT;
			pwr_q    <= {4{dfs_pkg::RST_FANPWR}};
			fmask_q  <= 4'h0;
			tmask_q  <= 32'h0;
			saved_q  <= 53'h0;
			slot_q   <= 3'h0;
			drv_q    <= {4{dfs_pkg::RST_FANPWR}};
			frv_q    <= 1'b0;
			fidx_q   <= 2'h0;
			trv_q    <= 1'b0;
			family_q <= 32'h0;
		end else begin
			state_q  <= state_d;
			cnt_q    <= cnt_d;
			addr_q   <= addr_d;
			buf_q    <= buf_d;
			rv_q     <= rv_d;
			rt_q     <= rt_d;
			rl_q     <= rl_d;
			col_q    <= col_d;
			row_q    <= row_d;
			sty_q    <= sty_d;
			con_q    <= con_d;
			bkl_q    <= bkl_d;
			pwr_q    <= pwr_d;
			fmask_q  <= fmask_d;
			tmask_q  <= tmask_d;
			saved_q  <= saved_d;
			slot_q   <= slot_d;
			drv_q    <= drv_d;
			frv_q    <= frv_d;
			fidx_q   <= fidx_d;
			trv_q    <= trv_d;
			family_q <= family_d;
		end
	end

	assign rsp_valid      = rv_q;
	assign rsp_type       = rt_q;
	assign rsp_len        = rl_q;
	assign rsp_data       = buf_q;
	assign cursor_col     = col_q;
	assign cursor_row     = row_q;
	assign cursor_style   = sty_q;
	assign contrast       = con_q;
	assign backlight      = bkl_q;
	assign fan_drive      = drv_q;
	assign fan_mask       = fmask_q;
	assign temp_mask      = tmask_q;
	assign saved_state    = saved_q;
	assign fan_rpt_valid  = frv_q;
	assign fan_rpt_idx    = fidx_q;
	assign temp_rpt_valid = trv_q;
	assign temp_rpt_mask  = tmask_q & family_q;

	default clocking cb @(posedge clock); endclocking
	default disable iff (!reset_n);
	a_read_reply_timing: assert property (take && cmd_type == dfs_pkg::TYP_MEMRD && cmd_len == dfs_pkg::LEN_ONE && ok |-> ##11 rsp_valid && rsp_type == 8'h4a && rsp_len == 5'h09)
		else $error("memory read reply late or wrong");
	a_read_burst_len: assert property ($rose(mem_rd) |-> mem_rd [*8] ##1 !mem_rd)
		else $error("memory read burst not eight bytes");
	a_read_echo_addr: assert property (rsp_valid && rsp_type == 8'h4a |-> rsp_data[7:0] == $past(addr_q))
		else $error("read reply lost the address");
	a_ack_type_or: assert property (take && ok && cmd_type != dfs_pkg::TYP_MEMRD |=> rsp_valid && rsp_type == ($past(cmd_type) | 8'h40))
		else $error("ack type wrong");
	a_error_reply: assert property (take && !ok |=> rsp_valid && rsp_type == ($past(cmd_type) | 8'hc0) && rsp_len == 5'h0)
		else $error("bad command not rejected");
	a_cursor_range: assert property (cursor_col <= 5'h13)
		else $error("cursor column out of range");
	a_contrast_range: assert property (take && cmd_type == dfs_pkg::TYP_CONTR && cmd_len == 5'h1 && cmd_data[7:0] == 8'hff |=> $stable(contrast))
		else $error("contrast 255 accepted");
	a_fan_force_full: assert property (fan_rpt_valid |=> fan_drive[7 * fan_rpt_idx +: 7] == 7'h64)
		else $error("reported fan not forced to full");
	a_fan4_silent: assert property (fan_rpt_valid |-> fan_rpt_idx != 2'h3 && fan_mask[fan_rpt_idx])
		else $error("report for a disabled or dead fan");
	a_save_capture: assert property (save_state |=> saved_state[4:0] == $past(cursor_col) && saved_state[8:7] == $past(cursor_style))
		else $error("saved state missed cursor");

	c_mem_read: cover property (rsp_valid && rsp_type == 8'h4a);
	c_sensor_read: cover property (rsp_valid && rsp_type == 8'h52);
	c_error: cover property (rsp_valid && rsp_type[7:6] == 2'b11);
	c_fan_report: cover property (fan_rpt_valid);
endmodule // dfs_cmd_handler
`default_nettype wire

// ===== bench/dfs_mem_model.sv
`timescale 1ns/100ps
`default_nettype none
module dfs_mem_model (
	input  wire logic       clock,
	input  wire logic       mem_rd,
	input  wire logic [7:0] mem_addr,
	output var  logic [7:0] mem_rd_data
);
	// one flat space covers glyph and character regions
	always @(posedge clock) begin
		if (mem_rd === 1'b1) begin
			mem_rd_data <= mem_addr ^ 8'ha5;
		end else begin
			// idle bus shows the inverse of a real read, so stale data never looks valid
			mem_rd_data <= ~(mem_addr ^ 8'ha5);
		end
	end
endmodule // dfs_mem_model
`default_nettype wire

// ===== bench/dfs_cmd_handler_test.sv
`timescale 1ns/100ps
`default_nettype none
module dfs_cmd_handler_test;
	localparam int EC = 10;
	logic        clock, reset_n, cmd_valid, cmd_ready, rsp_valid;
	logic        mem_rd, enum_wr, save_state, fan_rpt_valid, temp_rpt_valid;
	logic [7:0]  cmd_type, rsp_type, mem_addr, mem_rd_data, contrast;
	logic [4:0]  cmd_len, rsp_len, enum_idx, cursor_col;
	logic [31:0] cmd_data, temp_mask, temp_rpt_mask;
	logic [71:0] rsp_data, md;
	logic [63:0] enum_id;
	logic [1:0]  cursor_row, cursor_style, fan_rpt_idx;
	logic [6:0]  backlight;
	logic [27:0] fan_drive;
	logic [3:0]  fan_mask;
	logic [52:0] saved_state;
	logic [84:0] exp_q[$];
	logic [84:0] e;
	logic [7:0]  cv;
	logic [4:0]  col;
	int          error_cnt, comparisons, drv_cnt, tmp_cnt, i;
	int          fan_cnt[4];

	dfs_cmd_handler #(.EIGHTH_CYCLES(EC)) uut (.clock(clock), .reset_n(reset_n),
		.cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_type(cmd_type),
		.cmd_len(cmd_len), .cmd_data(cmd_data), .rsp_valid(rsp_valid),
		.rsp_type(rsp_type), .rsp_len(rsp_len), .rsp_data(rsp_data),
		.mem_rd(mem_rd), .mem_addr(mem_addr), .mem_rd_data(mem_rd_data),
		.enum_wr(enum_wr), .enum_idx(enum_idx), .enum_id(enum_id),
		.save_state(save_state), .cursor_col(cursor_col), .cursor_row(cursor_row),
		.cursor_style(cursor_style), .contrast(contrast), .backlight(backlight),
		.fan_drive(fan_drive), .fan_mask(fan_mask), .temp_mask(temp_mask),
		.saved_state(saved_state), .fan_rpt_valid(fan_rpt_valid),
		.fan_rpt_idx(fan_rpt_idx), .temp_rpt_valid(temp_rpt_valid),
		.temp_rpt_mask(temp_rpt_mask));
	dfs_mem_model mem (.clock(clock), .mem_rd(mem_rd), .mem_addr(mem_addr),
		.mem_rd_data(mem_rd_data));

	task automatic chk(input logic [71:0] got, input logic [71:0] exp);
		comparisons++;
		if (got !== exp) begin
			error_cnt++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic results();
		$display("errors=%0d comparisons=%0d", error_cnt, comparisons);
		if (error_cnt == 0 && comparisons > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask

	// the expected reply is queued before the command goes out
	task automatic send(input logic [7:0] t, input logic [4:0] l, input logic [31:0] d,
		input logic [7:0] rt, input logic [71:0] rd);
		exp_q.push_back({rt, (rt == 8'h4a || rt == 8'h52) ? 5'h09 : 5'h00, rd});
		@(negedge clock);
		while (cmd_ready !== 1'b1) @(negedge clock);
		@(posedge clock);
		cmd_valid <= 1'b1;
		cmd_type <= t;
		cmd_len <= l;
		cmd_data <= d;
		@(posedge clock);
		cmd_valid <= 1'b0;
	endtask

	task automatic bad(input logic [7:0] t, input logic [4:0] l, input logic [31:0] d);
		send(t, l, d, t | 8'hc0, 72'h0);
	endtask

	task automatic pulse_enum(input logic [4:0] idx, input logic [63:0] id);
		@(posedge clock);
		enum_wr <= 1'b1;
		enum_idx <= idx;
		enum_id <= id;
		@(posedge clock);
		enum_wr <= 1'b0;
	endtask

	always @(negedge clock) begin
		if (reset_n && rsp_valid === 1'b1) begin
			e = exp_q.size() ? exp_q.pop_front() : '1;
			chk(72'({rsp_type, rsp_len}), 72'(e[84:72]));
			if (e[76:72] == 5'h09) chk(rsp_data, e[71:0]);
		end
		if (fan_rpt_valid === 1'b1) fan_cnt[fan_rpt_idx]++;
		if (temp_rpt_valid === 1'b1) begin
			tmp_cnt++;
			chk(72'(temp_rpt_mask), 72'h20);
		end
		if (fan_drive[6:0] === 7'h64) drv_cnt++;
	end

	initial begin
		clock = 1'b0;
		forever #10 clock = ~clock;
	end

	initial begin
		repeat (5000) @(posedge clock);
		error_cnt++;
		results();
	end

	initial begin
		{reset_n, cmd_valid, cmd_type, cmd_len, cmd_data} = '0;
		{enum_wr, enum_idx, enum_id, save_state} = '0;
		void'($urandom(32'h5ee4));
		repeat (4) @(posedge clock);
		reset_n <= 1'b1;
		@(negedge clock);
		chk(72'({contrast, backlight, fan_drive}), 72'({8'h78, 7'h64, {4{7'h64}}}));
		bad(8'h0d, 5'h01, 32'hff);
		bad(8'h0d, 5'h02, 32'h10);
		for (i = 0; i < 3; i++) begin
			cv = 8'($urandom_range(254));
			send(8'h0d, 5'h01, 32'(cv), 8'h4d, 72'h0);
			@(negedge clock);
			chk(72'(contrast), 72'(cv));
		end
		col = 5'($urandom_range(19));
		send(8'h0b, 5'h02, {16'h0, 8'h03, 3'h0, col}, 8'h4b, 72'h0);
		bad(8'h0b, 5'h02, 32'h0314);
		send(8'h0c, 5'h01, 32'h3, 8'h4c, 72'h0);
		send(8'h0e, 5'h01, 32'h32, 8'h4e, 72'h0);
		bad(8'h0e, 5'h01, 32'h65);
		send(8'h11, 5'h04, 32'h05642100, 8'h51, 72'h0);
		bad(8'h11, 5'h04, 32'h00650000);
		@(negedge clock);
		chk(72'({cursor_row, cursor_col, fan_drive}), 72'({2'h3, col, 28'h0b91080}));
		chk(72'({cursor_style, backlight}), 72'({2'h3, 7'h32}));
		@(posedge clock);
		save_state <= 1'b1;
		@(posedge clock);
		save_state <= 1'b0;
		@(negedge clock);
		chk(72'(saved_state), 72'({28'h0b91080, 7'h32, cv, 2'h3, 2'h3, col}));
		for (i = 0; i < 2; i++) begin
			cv = i ? 8'he0 : 8'h7c;
			md = 72'(cv);
			for (int n = 0; n < 8; n++) md[8*n+8 +: 8] = (cv + 8'(n)) ^ 8'ha5;
			send(8'h0a, 5'h01, 32'(cv), 8'h4a, md);
		end
		bad(8'h0a, 5'h01, 32'h94);
		pulse_enum(5'h05, 64'h0123456789abcd5a);
		pulse_enum(5'h06, 64'h0123456789abcd11);
		send(8'h12, 5'h01, 32'h5, 8'h52, {64'h0123456789abcd5a, 8'h05});
		bad(8'h12, 5'h01, 32'h20);
		bad(8'h10, 5'h01, 32'h10);
		send(8'h10, 5'h01, 32'h0f, 8'h50, 72'h0);
		send(8'h13, 5'h04, 32'h20, 8'h53, 72'h0);
		@(posedge clock);
		{fan_cnt[0], fan_cnt[1], fan_cnt[2], fan_cnt[3], drv_cnt, tmp_cnt} = '0;
		repeat (8 * EC) @(posedge clock);
		chk(72'({4'(fan_cnt[0]), 4'(fan_cnt[1]), 4'(fan_cnt[2])}), 72'h222);
		chk(72'(fan_cnt[3]), 72'h0);
		chk(72'(drv_cnt), 72'(2 * EC));
		chk(72'({tmp_cnt, temp_mask}), 72'({32'h1, 32'h20}));
		chk(72'(fan_mask), 72'hf);
		repeat (20) @(negedge clock);
		chk(72'(exp_q.size()), 72'h0);
		results();
	end
endmodule // dfs_cmd_handler_test
`default_nettype wire
